// [common/ssm_pkg.sv]
// Constants for the shared serial module SPI port
// What this block does
// RULE1 - Master mode codes 000/001/010 clock the bit clock at system clock /4, /16, /64.
// RULE2 - Code 011 clocks master from sub clock; 100 at half timer-zero match rate.
// RULE3 - Code 101 is slave mode; serial clock comes only from the external master.
// RULE4 - Mode field selects SPI or I2C; 110 is I2C slave, 111 unused.
// RULE5 - Module enable low releases every interface line and idles the logic.
// RULE6 - Enable rising in SPI mode keeps all SPI control settings unchanged.
// RULE7 - Enable rising in I2C mode keeps direction/ack bits, resets I2C status flags.
// RULE8 - Slave with enable and select enable: early select rise sets incomplete and complete.
// RULE9 - An incomplete slave transfer raises the module interrupt when interrupts are enabled.
// RULE10 - Software writing incomplete flag to one does not set transfer complete flag.
// RULE11 - Incomplete flag is only set by hardware in SPI slave mode.
// RULE12 - Select enable one uses the select pin; zero leaves it floating.
// RULE13 - Master starts every transfer and drives clock; slave only follows.
// RULE14 - Software loads the data register before a transfer; all data passes through it.
// RULE15 - A received byte becomes readable in the data register.
// RULE16 - Full duplex, selectable bit order, selectable active edge, complete flag.
// RULE17 - Debounce select bits only matter in I2C mode, not in SPI.
// RULE18 - Bit 4 of the mode control register always reads zero.
// RULE19 - Masters needing several slaves drive extra selects from general I/O.
// RULE20 - Each transfer shifts exactly eight bits; complete flag follows the eighth sample.
// RULE21 - Data write during a transfer sets write collision and leaves the shift intact.
package ssm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFF_AUX_CTRL  = 8'h04;
    localparam logic [7:0] OFF_SHIFT_DAT = 8'h08;
    localparam logic [7:0] OFF_I2C_CTRL  = 8'h0c;
    // Values after reset
    localparam logic [2:0] RST_MODE      = 3'h7;
    localparam logic [7:0] RST_AUX       = 8'h00;
    localparam logic [7:0] RST_DATA      = 8'h00;
    // Operating mode codes
    localparam logic [2:0] MODE_DIV4     = 3'h0;
    localparam logic [2:0] MODE_DIV16    = 3'h1;
    localparam logic [2:0] MODE_DIV64    = 3'h2;
    localparam logic [2:0] MODE_SUB      = 3'h3;
    localparam logic [2:0] MODE_TMR      = 3'h4;
    localparam logic [2:0] MODE_SLAVE    = 3'h5;
    localparam logic [2:0] MODE_I2C      = 3'h6;
    // Half bit-clock periods in system clock cycles
    localparam logic [5:0] HALF_DIV4     = 6'(4 / 2);
    localparam logic [5:0] HALF_DIV16    = 6'(16 / 2);
    localparam logic [5:0] HALF_DIV64    = 6'(64 / 2);
    // Clock edges per byte, last edge index
    localparam logic [3:0] LAST_EDGE     = 4'hf;
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// [rtl/ssm_bit_clock_div.sv]
// Master bit clock half-period tick generator
`timescale 1ns/10ps
module ssm_bit_clock_div (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] mode,
    // Alternate clock sources, already in this domain
    input  wire logic       sub_edge,
    input  wire logic       tmr_match,
    // One pulse per half bit period
    output logic            tick
);
    typedef struct packed {
        logic [5:0] cnt;
    } ssm_div_state_t;

    ssm_div_state_t st;
    ssm_div_state_t next_st;
    logic [5:0]     half;

    always_comb begin
        next_st = st;
        tick    = 1'b0;
        case (mode)
            ssm_pkg::MODE_DIV4:  half = ssm_pkg::HALF_DIV4;
            ssm_pkg::MODE_DIV16: half = ssm_pkg::HALF_DIV16;
            default:             half = ssm_pkg::HALF_DIV64;
        endcase
        // Counter held at zero while idle so it draws no toggling power
        if (!run) begin
            next_st.cnt = 6'h00;
        end else if (mode == ssm_pkg::MODE_SUB) begin
            tick = sub_edge; // RULE2
        end else if (mode == ssm_pkg::MODE_TMR) begin
            tick = tmr_match; // RULE2
        end else if (st.cnt == half - 6'h01) begin
            tick        = 1'b1; // RULE1
            next_st.cnt = 6'h00;
        end else begin
            next_st.cnt = st.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// [rtl/ssm_spi_port.sv]
// Shared serial module SPI port with AHB-Lite register slave
`timescale 1ns/10ps
module ssm_spi_port (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Serial clock pin
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    // Serial data pins
    input  wire logic        sdi,
    output logic             sdo_out,
    output logic             sdo_oe,
    // Slave select pin
    input  wire logic        scs_n_in,
    output logic             scs_n_out,
    output logic             scs_n_oe,
    // Alternate master clock sources
    input  wire logic        sub_clk,
    input  wire logic        tmr_match,
    // Interrupt
    input  wire logic        irq_enable,
    output logic             module_irq
);
    typedef struct packed {
        logic [2:0]  mode;
        logic [1:0]  deb;
        logic        en;
        logic        icf;
        logic [1:0]  aux_hi;
        logic        cpol;
        logic        clock_active_edge;
        logic        bit_order_select;
        logic        slave_select_enable;
        logic        write_collision_flag;
        logic        transfer_complete_flag;
        logic [7:0]  data;
        logic [7:0]  sh;
        logic        rx;
        logic        busy;
        logic [3:0]  edge_cnt;
        logic        sck_lvl;
        logic        sck_d;
        logic        scs_d;
        logic        sub_d;
        logic        en_d;
        logic        i2c_transmit_direction;
        logic        i2c_ack_to_send;
        logic [4:0]  i2c_flags;
        logic        ph_wr;
        logic [7:0]  ph_addr;
        logic [31:0] rdata;
        logic        irq;
    } ssm_state_t;

    ssm_state_t  st;
    ssm_state_t  next_st;
    logic [1:0]  rst_q;
    logic        rst_n;
    logic [3:0]  sync_out;
    logic        sck_s;
    logic        sdi_s;
    logic        scs_s;
    logic        sub_s;
    logic        is_master;
    logic        is_slave;
    logic        spi_on;
    logic        div_tick;
    logic        sel_ok;
    logic        bit_edge;
    logic        smp;
    logic        done_ev;
    logic        abort_ev;
    logic        acc;
    logic        mc_wr;
    logic        ac_wr;
    logic        sd_wr;
    logic        i2_wr;
    logic [7:0]  wdat;

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic msb_first);
        shift_in = msb_first ? {v[6:0], b} : {b, v[7:1]};
    endfunction

    // Reset release through two flops so all logic leaves reset together
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    ssm_sync2 #(
        .W (4)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({sub_clk, scs_n_in, sdi, sck_in}),
        .dout  (sync_out)
    );
    assign sck_s = sync_out[0];
    assign sdi_s = sync_out[1];
    assign scs_s = sync_out[2];
    assign sub_s = sync_out[3];

    // Codes 110 and 111 leave the SPI engine idle
    assign is_master = (st.mode <= ssm_pkg::MODE_TMR); // RULE4
    assign is_slave  = (st.mode == ssm_pkg::MODE_SLAVE); // RULE3
    assign spi_on    = st.en && (is_master || is_slave); // RULE5

    ssm_bit_clock_div u_div (
        .clk       (clk),
        .rst_n     (rst_n),
        .run       (spi_on && is_master && st.busy),
        .mode      (st.mode),
        .sub_edge  (sub_s != st.sub_d),
        .tmr_match (tmr_match),
        .tick      (div_tick)
    );

    // Slave follows the external clock while selected, or at all times with select enable off
    assign sel_ok   = !st.slave_select_enable || !scs_s; // RULE12
    assign bit_edge = is_master ? div_tick
                                : (spi_on && is_slave && sel_ok && sck_s != st.sck_d); // RULE13
    assign smp      = st.clock_active_edge ? st.edge_cnt[0] : !st.edge_cnt[0]; // RULE16
    assign done_ev  = bit_edge && st.edge_cnt == ssm_pkg::LAST_EDGE; // RULE20
    assign abort_ev = spi_on && is_slave && st.slave_select_enable && scs_s && !st.scs_d
                      && st.busy && !done_ev; // RULE8 RULE11

    assign acc   = hsel && htrans[1] && hready;
    assign wdat  = hwdata[7:0];
    assign mc_wr = st.ph_wr && st.ph_addr == ssm_pkg::OFF_MODE_CTRL;
    assign ac_wr = st.ph_wr && st.ph_addr == ssm_pkg::OFF_AUX_CTRL;
    assign sd_wr = st.ph_wr && st.ph_addr == ssm_pkg::OFF_SHIFT_DAT;
    assign i2_wr = st.ph_wr && st.ph_addr == ssm_pkg::OFF_I2C_CTRL;

    always_comb begin
        next_st       = st;
        next_st.sck_d = sck_s;
        next_st.scs_d = scs_s;
        next_st.sub_d = sub_s;
        next_st.en_d  = st.en;
        next_st.ph_wr   = acc && hwrite && hsize == ssm_pkg::HSIZE_WORD;
        next_st.ph_addr = haddr;

        // Software writes land first so hardware events below win over clears
        if (mc_wr) begin
            next_st.mode = wdat[7:5];
            next_st.deb  = wdat[3:2]; // RULE17
            next_st.en   = wdat[1];
            next_st.icf  = wdat[0]; // RULE10
        end
        if (ac_wr) begin
            next_st.aux_hi = wdat[7:6];
            next_st.cpol   = wdat[5];
            next_st.clock_active_edge   = wdat[4];
            next_st.bit_order_select    = wdat[3];
            next_st.slave_select_enable   = wdat[2];
            next_st.write_collision_flag   = wdat[1];
            next_st.transfer_complete_flag    = wdat[0];
        end
        if (i2_wr) begin
            next_st.i2c_transmit_direction  = wdat[0];
            next_st.i2c_ack_to_send = wdat[1];
        end
        if (sd_wr) begin
            if (st.busy) begin
                next_st.write_collision_flag = 1'b1; // RULE21
            end else begin
                next_st.data = wdat; // RULE14
                next_st.sh   = wdat;
                if (spi_on && is_master) begin
                    next_st.busy     = 1'b1; // RULE13
                    next_st.edge_cnt = 4'h0;
                end
            end
        end

        // Master clock rests at its idle level between bytes
        if (!st.busy) begin
            next_st.sck_lvl = st.cpol;
        end

        if (bit_edge) begin
            next_st.busy     = 1'b1;
            next_st.edge_cnt = st.edge_cnt + 4'h1;
            if (is_master) begin
                next_st.sck_lvl = !st.sck_lvl;
            end
            // Master takes its input bit half a bit late: the pin synchroniser
            // delays the peer's answer two clocks, a whole half period at /4
            if (smp) begin
                next_st.rx = sdi_s; // RULE16
            end else if (st.edge_cnt != 4'h0) begin
                next_st.sh = shift_in(st.sh, is_master ? sdi_s : st.rx, st.bit_order_select);
            end
            if (done_ev) begin
                next_st.sh       = shift_in(st.sh, (st.clock_active_edge || is_master) ? sdi_s : st.rx,
                                            st.bit_order_select);
                next_st.data     = next_st.sh; // RULE15
                next_st.transfer_complete_flag      = 1'b1; // RULE20
                next_st.busy     = 1'b0;
                next_st.edge_cnt = 4'h0;
            end
        end

        if (abort_ev) begin
            next_st.icf      = 1'b1; // RULE8
            next_st.transfer_complete_flag      = 1'b1;
            next_st.busy     = 1'b0;
            next_st.edge_cnt = 4'h0;
            next_st.sh       = st.data;
        end

        // Disabling drops any byte in flight; control bits are kept
        if (!spi_on) begin
            next_st.busy     = 1'b0; // RULE5
            next_st.edge_cnt = 4'h0;
        end

        // Enable rise reinitialises nothing in SPI mode; I2C status returns to default
        if (st.en && !st.en_d && st.mode == ssm_pkg::MODE_I2C) begin
            next_st.i2c_flags = 5'h00; // RULE6 RULE7
        end

        next_st.irq = irq_enable && (done_ev || abort_ev); // RULE9

        // Read data taken from the updated state so a preceding write is visible
        next_st.rdata = 32'h0000_0000;
        if (acc && !hwrite) begin
            if (haddr == ssm_pkg::OFF_MODE_CTRL) begin
                next_st.rdata[7:0] = {next_st.mode, 1'b0, next_st.deb,
                                      next_st.en, next_st.icf}; // RULE18
            end else if (haddr == ssm_pkg::OFF_AUX_CTRL) begin
                next_st.rdata[7:0] = {next_st.aux_hi, next_st.cpol, next_st.clock_active_edge,
                                      next_st.bit_order_select, next_st.slave_select_enable, next_st.write_collision_flag,
                                      next_st.transfer_complete_flag};
            end else if (haddr == ssm_pkg::OFF_SHIFT_DAT) begin
                next_st.rdata[7:0] = next_st.data;
            end else if (haddr == ssm_pkg::OFF_I2C_CTRL) begin
                next_st.rdata[7:0] = {1'b0, next_st.i2c_flags, next_st.i2c_ack_to_send, next_st.i2c_transmit_direction};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st      <= '0;
            st.mode <= ssm_pkg::RST_MODE;
            st.data <= ssm_pkg::RST_DATA;
            st.sh   <= ssm_pkg::RST_DATA;
            {st.aux_hi, st.cpol, st.clock_active_edge, st.bit_order_select, st.slave_select_enable, st.write_collision_flag, st.transfer_complete_flag}
                    <= ssm_pkg::RST_AUX;
            st.sck_d <= 1'b0;
            st.scs_d <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Zero wait state slave, always OKAY
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = st.rdata;
    assign module_irq = st.irq;

    // Pin drivers; every enable drops with the module enable
    assign sck_out   = st.sck_lvl;
    assign sck_oe    = spi_on && is_master; // RULE3 RULE5
    assign sdo_out   = st.bit_order_select ? st.sh[7] : st.sh[0];
    assign sdo_oe    = spi_on && (is_master || sel_ok); // RULE5
    assign scs_n_out = !st.busy;
    assign scs_n_oe  = spi_on && is_master && st.slave_select_enable; // RULE12

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_div4_half;
        (st.busy && st.mode == ssm_pkg::MODE_DIV4 && $changed(st.sck_lvl))
            |=> ($stable(st.sck_lvl) ##1 ($changed(st.sck_lvl) || !st.busy));
    endproperty
    a_div4_half: assert property (p_div4_half) else $error("div4 half period wrong"); // RULE1

    property p_slave_no_clock;
        is_slave |-> !sck_oe;
    endproperty
    a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drives sck"); // RULE3

    property p_disable_float;
        !st.en |-> !(sck_oe || sdo_oe || scs_n_oe);
    endproperty
    a_disable_float: assert property (p_disable_float) else $error("pin driven when off"); // RULE5

    property p_abort_flags;
        abort_ev |=> (st.icf && st.transfer_complete_flag && !st.busy && st.edge_cnt == 4'h0);
    endproperty
    a_abort_flags: assert property (p_abort_flags) else $error("abort flags missing"); // RULE8

    property p_abort_irq;
        (abort_ev && irq_enable) |=> module_irq ##1 !module_irq || abort_ev || done_ev;
    endproperty
    a_abort_irq: assert property (p_abort_irq) else $error("no interrupt on abort"); // RULE9

    property p_sw_icf;
        (mc_wr && wdat[0] && !st.transfer_complete_flag && !ac_wr && !done_ev && !abort_ev)
            |=> (st.icf && !st.transfer_complete_flag);
    endproperty
    a_sw_icf: assert property (p_sw_icf) else $error("sw icf set trf"); // RULE10

    property p_icf_slave_only;
        (!is_slave && !mc_wr) |=> !$rose(st.icf);
    endproperty
    a_icf_slave_only: assert property (p_icf_slave_only) else $error("icf set outside slave"); // RULE11

    property p_slave_select_enable_float;
        !st.slave_select_enable |-> !scs_n_oe;
    endproperty
    a_slave_select_enable_float: assert property (p_slave_select_enable_float) else $error("select driven, slave_select_enable off"); // RULE12

    property p_bit4_zero;
        (acc && !hwrite && haddr == ssm_pkg::OFF_MODE_CTRL) |=> !hrdata[4];
    endproperty
    a_bit4_zero: assert property (p_bit4_zero) else $error("mode bit 4 not zero"); // RULE18

    property p_eight_bits;
        (bit_edge && st.edge_cnt == 4'he) |-> ##[1:200] (done_ev || !st.busy) ##1 !st.busy;
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("byte did not end"); // RULE20

    property p_done_readable;
        done_ev |=> (st.transfer_complete_flag && st.data == st.sh);
    endproperty
    a_done_readable: assert property (p_done_readable) else $error("rx byte not loaded"); // RULE15

    property p_write_collision_flag;
        (sd_wr && st.busy) |=> (st.write_collision_flag && $stable(st.data));
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // RULE21

    c_master_done: cover property (is_master && done_ev);
    c_slave_done:  cover property (is_slave && done_ev);
    c_abort:       cover property (abort_ev);
    c_collision:   cover property (sd_wr && st.busy);
endmodule

// [rtl/ssm_sync2.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ssm_sync2 #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous levels in, synchronised out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssm_sync_state_t;

    ssm_sync_state_t st;
    ssm_sync_state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // First stage feeds only the second stage
    assign dout = st.s2;
endmodule

// [verif/ssm_peer_model.sv]
// Behavioural SPI peer that plays either master or slave against the port
`timescale 1ns/10ps
module ssm_peer_model (
    // Clock and resolved lines
    input  wire logic clk,
    input  wire logic sck,
    input  wire logic sel_n,
    input  wire logic din,
    // Peer drive
    output logic      dout,
    output logic      m_sck,
    output logic      m_sel_n
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;

    initial begin
        m_sck = 1'b0;
        m_sel_n = 1'b1;
    end

    // Released line shows the inverse of its bit so a stale bit never passes as data
    assign dout = sel_n ? ~tx[7] : tx[7];
    always @(posedge sck) rx <= {rx[6:0], din};
    always @(negedge sck) tx <= {tx[6:0], 1'b0};

    task automatic load(input logic [7:0] b);
        tx = b;
    endtask

    // Peer as master: clock stands still outside the frame
    task automatic xfer(input int n);
        m_sel_n <= 1'b0;
        repeat (8) @(posedge clk);
        repeat (n) begin
            m_sck <= 1'b1;
            repeat (8) @(posedge clk);
            m_sck <= 1'b0;
            repeat (8) @(posedge clk);
        end
        m_sel_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// [verif/test_serial_module_spi_port.sv]
// Self-checking bench for the shared serial module SPI port
`timescale 1ns/10ps
module test_serial_module_spi_port;
    localparam logic [7:0] MC = ssm_pkg::OFF_MODE_CTRL;
    localparam logic [7:0] AX = ssm_pkg::OFF_AUX_CTRL;
    localparam logic [7:0] DT = ssm_pkg::OFF_SHIFT_DAT;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = ssm_pkg::HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic        sub_clk = 1'b0;
    logic        tmr_match = 1'b0;
    logic        irq_enable = 1'b1;
    logic        hreadyout, hresp, sck_out, sck_oe, sdo_out, sdo_oe;
    logic        scs_n_out, scs_n_oe, module_irq, p_dout, p_sck, p_sel_n;
    logic [31:0] hrdata;
    logic        sck_q = 1'b0;
    int          err_total = 0;
    int          checks = 0;
    int          cyc = 0;
    int          run = 0;
    int          gap = 0;
    int          irq_cnt = 0;
    int          irq0;
    logic        msb;
    logic [7:0]  db, pb;
    wire         sck_ln = sck_oe ? sck_out : p_sck;
    wire         sel_ln = scs_n_oe ? scs_n_out : p_sel_n;
    wire         sdo_ln = sdo_oe ? sdo_out : ~sdo_out;

    ssm_spi_port u_ssm_spi_port (
        .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck_in(sck_ln),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdi(p_dout), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .scs_n_in(sel_ln), .scs_n_out(scs_n_out),
        .scs_n_oe(scs_n_oe), .sub_clk(sub_clk), .tmr_match(tmr_match),
        .irq_enable(irq_enable), .module_irq(module_irq));

    ssm_peer_model u_ssm_peer_model (
        .clk(clk), .sck(sck_ln), .sel_n(sel_ln), .din(sdo_ln),
        .dout(p_dout), .m_sck(p_sck), .m_sel_n(p_sel_n));

    always #12.5 clk = ~clk;

    // Free-running alternate clock sources, a half bit every 4 clk
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sub_clk <= cyc[2];
        tmr_match <= (cyc[1:0] == 2'h3);
        if (module_irq === 1'b1) irq_cnt <= irq_cnt + 1;
        sck_q <= sck_out;
        if (sck_out !== sck_q) begin
            gap <= run;
            run <= 1;
        end else run <= run + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict;
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic xfr(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfr(a, 1'b1, d, q);
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfr(a, 1'b0, 8'h00, q);
        chk(n, q, e);
    endtask

    // Bounded poll on the complete flag
    task automatic wait_done;
        logic [31:0] q;
        int n;
        q = 32'h0;
        n = 0;
        while (q[0] !== 1'b1 && n < 1000) begin
            xfr(AX, 1'b0, 8'h00, q);
            n++;
        end
    endtask

    function automatic logic [7:0] rev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev[i] = b[7-i];
    endfunction

    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk("mode_ctrl", MC, 32'he0);
        rchk("aux_ctrl", AX, 32'h00);
        rchk("unmapped", 8'h10, 32'h0);
        wr(MC, 8'hfc);
        rchk("bit4", MC, 32'hec);
        $display("test reset done");
        // Every master mode, bit order alternating, collision mid-byte
        for (int m = 0; m < 5; m++) begin
            msb = (m % 2) == 0;
            db = 8'ha5 ^ 8'(m);
            pb = 8'h1e + 8'(m);
            wr(AX, {4'h0, msb, 3'h4});
            wr(MC, {3'(m), 5'h02});
            u_ssm_peer_model.load(pb);
            wr(DT, db);
            wr(DT, 8'h77);
            chk("select_oe", {31'h0, scs_n_oe}, 32'h1);
            wait_done;
            chk("peer_rx", {24'h0, u_ssm_peer_model.rx}, {24'h0, msb ? db : rev(db)});
            rchk("data", DT, {24'h0, msb ? pb : rev(pb)});
            rchk("aux", AX, {28'h0, msb, 3'h7});
            rchk("mode", MC, {24'h0, 3'(m), 5'h02});
            chk("half", 32'(gap), m < 3 ? (32'd2 << (2 * m)) : 32'd4);
        end
        wr(AX, 8'h08);
        @(posedge clk);
        chk("select_float", {31'h0, scs_n_oe}, 32'h0);
        // Peer selected by a bench line standing in for a general I/O pin
        u_ssm_peer_model.m_sel_n <= 1'b0;
        u_ssm_peer_model.load(8'h3c);
        wr(DT, 8'h5a);
        wait_done;
        u_ssm_peer_model.m_sel_n <= 1'b1;
        chk("gpio_sel_rx", {24'h0, u_ssm_peer_model.rx}, 32'h5a);
        rchk("gpio_sel_data", DT, 32'h3c);
        $display("test master done");
        // Slave byte, then a frame cut short by the select
        wr(AX, 8'h0c);
        wr(MC, {ssm_pkg::MODE_SLAVE, 5'h02});
        wr(DT, 8'hc3);
        u_ssm_peer_model.load(8'h96);
        u_ssm_peer_model.xfer(8);
        rchk("slave_data", DT, 32'h96);
        chk("slave_peer", {24'h0, u_ssm_peer_model.rx}, 32'hc3);
        rchk("slave_aux", AX, 32'h0d);
        irq0 = irq_cnt;
        wr(AX, 8'h0c);
        u_ssm_peer_model.xfer(3);
        rchk("incomplete", MC, 32'ha3);
        rchk("abort_trf", AX, 32'h0d);
        chk("irq", 32'(irq_cnt - irq0), 32'h1);
        wr(AX, 8'h0c);
        wr(MC, 8'ha3);
        rchk("sw_icf", AX, 32'h0c);
        $display("test slave done");
        // Disable, re-enable, I2C mode
        wr(MC, 8'ha0);
        @(posedge clk);
        chk("oe_off", {29'h0, sck_oe, sdo_oe, scs_n_oe}, 32'h0);
        wr(MC, 8'ha2);
        rchk("aux_kept", AX, 32'h0c);
        wr(MC, 8'hc2);
        wr(DT, 8'h11);
        repeat (20) @(posedge clk);
        chk("i2c_idle", {30'h0, sck_oe, sdo_oe}, 32'h0);
        rchk("i2c_trf", AX, 32'h0c);
        wr(8'h0c, 8'h03);
        wr(MC, 8'hc0);
        wr(MC, 8'hc2);
        rchk("i2c_bits", 8'h0c, 32'h03);
        $display("test modes done");
        print_verdict;
    end
endmodule
